// file: hw/serial_rx_phy_control_regs.sv
// Purpose : control bank of a four-lane serial receiver front end
// Assumes : control port pins are asynchronous to SYS_CLK
// Notes   : every control output comes straight from a flip-flop
`timescale 1ns/1ps
// Behaviour
// - master bit powers down all lanes, bias
// - per-lane power-down mask, bit x lane x
// - misc bit 1 powers down sync buffer
// - active-low recovery reset, resets to released
// - half-rate enable for high lane rates
// - oversample enable for low lane rates
// - mode bit 0 picks sync output swing
module serial_rx_phy_control_regs #(
  parameter int LANES = rx_phy_ctrl_pkg::LANES
) (
  input  wire logic             SYS_CLK,
  input  wire logic             RESET_N,
  input  wire logic             CLK_EN,
  input  wire logic             SCLK,
  input  wire logic             CS_N,
  input  wire logic             SDI,
  output logic                  SDO,
  output logic                  SDO_OE_N,
  output logic                  RECEIVER_POWER_DOWN_ALL,
  output logic                  BIAS_POWER_DOWN,
  output logic [LANES-1:0]      LANE_POWER_DOWN,
  output logic                  SYNC_OUT_BUFFER_POWER_DOWN,
  output logic                  RECOVERY_RESET_N,
  output logic                  HALF_RATE_RECOVERY_ENABLE,
  output logic                  INPUT_OVERSAMPLE_ENABLE,
  output logic                  SYNC_OUT_SWING_SELECT
);
  logic [1:0]       rst_pipe;
  logic             rst_n;
  logic [1:0]       sclk_pipe;
  logic [1:0]       cs_pipe;
  logic [1:0]       sdi_pipe;
  logic [7:0]       receiver_master_power_down, next_receiver_master_power_down;
  logic [7:0]       lane_pd, next_lane_pd;
  logic [7:0]       misc_pd, next_misc_pd;
  logic [7:0]       rec_rst, next_rec_rst;
  logic [7:0]       op_mode, next_op_mode;
  logic [7:0]       rdata, next_rdata;
  logic [LANES-1:0] lane_out, next_lane_out;

  spi_frame_if bus ();

  function automatic logic hit(input logic [14:0] a,
                               input logic [14:0] off);
    return a == off;
  endfunction

  // ==========================================================
  // reset release and pin synchronisers
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_pipe <= 2'h0;
    end else if (CLK_EN) begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // cs idles high so a reset never looks like a frame start
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sclk_pipe <= 2'h0;
      cs_pipe   <= 2'h3;
      sdi_pipe  <= 2'h0;
    end else if (CLK_EN) begin
      sclk_pipe <= {sclk_pipe[0], SCLK};
      cs_pipe   <= {cs_pipe[0], CS_N};
      sdi_pipe  <= {sdi_pipe[0], SDI};
    end
  end

  spi_frame_engine u_engine (
    .clk      (SYS_CLK),
    .rst_n    (rst_n),
    .ce       (CLK_EN),
    .sclk_s   (sclk_pipe[1]),
    .cs_n_s   (cs_pipe[1]),
    .sdi_s    (sdi_pipe[1]),
    .sdo      (SDO),
    .sdo_oe_n (SDO_OE_N),
    .bus      (bus.engine)
  );

  // ==========================================================
  // register file
  always_comb begin
    next_receiver_master_power_down = receiver_master_power_down;
    next_lane_pd   = lane_pd;
    next_misc_pd   = misc_pd;
    next_rec_rst   = rec_rst;
    next_op_mode   = op_mode;
    next_rdata     = rdata;
    // whole bytes stored, reserved bits included
    if (bus.wr_strobe) begin
      if (hit(bus.addr, rx_phy_ctrl_pkg::OFF_RECEIVER_MASTER_POWER_DOWN))
        next_receiver_master_power_down = bus.wdata;
      if (hit(bus.addr, rx_phy_ctrl_pkg::OFF_LANE_PD))
        next_lane_pd = bus.wdata;
      if (hit(bus.addr, rx_phy_ctrl_pkg::OFF_MISC_PD))
        next_misc_pd = bus.wdata;
      if (hit(bus.addr, rx_phy_ctrl_pkg::OFF_REC_RST))
        next_rec_rst = bus.wdata;
      // bits 4:2 stored as written; keeping them at 2 is up to software
      if (hit(bus.addr, rx_phy_ctrl_pkg::OFF_OP_MODE))
        next_op_mode = bus.wdata;
    end
    if (bus.rd_strobe) begin
      next_rdata = rx_phy_ctrl_pkg::UNMAPPED_READ;
      if (hit(bus.addr, rx_phy_ctrl_pkg::OFF_RECEIVER_MASTER_POWER_DOWN))
        next_rdata = receiver_master_power_down;
      if (hit(bus.addr, rx_phy_ctrl_pkg::OFF_LANE_PD))
        next_rdata = lane_pd;
      if (hit(bus.addr, rx_phy_ctrl_pkg::OFF_MISC_PD))
        next_rdata = misc_pd;
      if (hit(bus.addr, rx_phy_ctrl_pkg::OFF_REC_RST))
        next_rdata = rec_rst;
      if (hit(bus.addr, rx_phy_ctrl_pkg::OFF_OP_MODE))
        next_rdata = op_mode;
    end
    // master overrides the per-lane mask for every lane
    next_lane_out = next_lane_pd[LANES-1:0] |
                    {LANES{next_receiver_master_power_down[rx_phy_ctrl_pkg::BIT_RECEIVER_MASTER_POWER_DOWN]}};
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      receiver_master_power_down <= rx_phy_ctrl_pkg::RST_RECEIVER_MASTER_POWER_DOWN;
      lane_pd   <= rx_phy_ctrl_pkg::RST_LANE_PD;
      misc_pd   <= rx_phy_ctrl_pkg::RST_MISC_PD;
      rec_rst   <= rx_phy_ctrl_pkg::RST_REC_RST;
      op_mode   <= rx_phy_ctrl_pkg::RST_OP_MODE;
      rdata     <= rx_phy_ctrl_pkg::UNMAPPED_READ;
      lane_out  <= '1;
    end else if (CLK_EN) begin
      receiver_master_power_down <= next_receiver_master_power_down;
      lane_pd   <= next_lane_pd;
      misc_pd   <= next_misc_pd;
      rec_rst   <= next_rec_rst;
      op_mode   <= next_op_mode;
      rdata     <= next_rdata;
      lane_out  <= next_lane_out;
    end
  end

  assign bus.rdata = rdata;

  // ==========================================================
  // control outputs
  assign RECEIVER_POWER_DOWN_ALL =
    receiver_master_power_down[rx_phy_ctrl_pkg::BIT_RECEIVER_MASTER_POWER_DOWN];
  assign BIAS_POWER_DOWN = receiver_master_power_down[rx_phy_ctrl_pkg::BIT_RECEIVER_MASTER_POWER_DOWN];
  assign LANE_POWER_DOWN = lane_out;
  assign SYNC_OUT_BUFFER_POWER_DOWN =
    misc_pd[rx_phy_ctrl_pkg::BIT_SYNC_PD];
  assign RECOVERY_RESET_N = rec_rst[rx_phy_ctrl_pkg::BIT_REC_RST_N];
  assign HALF_RATE_RECOVERY_ENABLE =
    op_mode[rx_phy_ctrl_pkg::BIT_HALF_RATE];
  assign INPUT_OVERSAMPLE_ENABLE =
    op_mode[rx_phy_ctrl_pkg::BIT_OVERSAMPLE];
  assign SYNC_OUT_SWING_SELECT = op_mode[rx_phy_ctrl_pkg::BIT_SWING];

  // ==========================================================
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  master_all_a: assert property (
    RECEIVER_POWER_DOWN_ALL |-> (&LANE_POWER_DOWN) && BIAS_POWER_DOWN)
    else $error("master power-down left a lane or bias on");

  master_reset_a: assert property (
    $rose(rst_n) |-> RECEIVER_POWER_DOWN_ALL && RECOVERY_RESET_N
                     && HALF_RATE_RECOVERY_ENABLE && !INPUT_OVERSAMPLE_ENABLE)
    else $error("wrong control state after reset");

  lane_map_a: assert property (
    !RECEIVER_POWER_DOWN_ALL |-> LANE_POWER_DOWN == lane_pd[LANES-1:0])
    else $error("lane power-down does not follow its mask");

  lane_write_a: assert property (
    CLK_EN && bus.wr_strobe && hit(bus.addr, rx_phy_ctrl_pkg::OFF_LANE_PD)
    |=> lane_pd == $past(bus.wdata))
    else $error("lane mask write not stored");

  sync_pd_a: assert property (
    CLK_EN && bus.wr_strobe && hit(bus.addr, rx_phy_ctrl_pkg::OFF_MISC_PD)
    |=> SYNC_OUT_BUFFER_POWER_DOWN == $past(bus.wdata[1]))
    else $error("sync buffer power-down not taken");

  recovery_rst_a: assert property (
    CLK_EN && bus.wr_strobe && hit(bus.addr, rx_phy_ctrl_pkg::OFF_REC_RST)
    |=> RECOVERY_RESET_N == $past(bus.wdata[0]))
    else $error("recovery reset not taken");

  half_rate_a: assert property (
    CLK_EN && bus.wr_strobe && hit(bus.addr, rx_phy_ctrl_pkg::OFF_OP_MODE)
    |=> HALF_RATE_RECOVERY_ENABLE == $past(bus.wdata[5]))
    else $error("half-rate enable not taken");

  oversample_a: assert property (
    CLK_EN && bus.wr_strobe && hit(bus.addr, rx_phy_ctrl_pkg::OFF_OP_MODE)
    |=> INPUT_OVERSAMPLE_ENABLE == $past(bus.wdata[1]))
    else $error("oversample enable not taken");

  swing_sel_a: assert property (
    !(CLK_EN && bus.wr_strobe) |=> $stable(SYNC_OUT_SWING_SELECT))
    else $error("swing select changed without a write");

  reserved_store_a: assert property (
    CLK_EN && bus.wr_strobe && hit(bus.addr, rx_phy_ctrl_pkg::OFF_MISC_PD)
    |=> misc_pd == $past(bus.wdata) && $stable(RECOVERY_RESET_N))
    else $error("misc byte not stored whole");
endmodule

// file: hw/spi_frame_engine.sv
// Purpose : serial control port frame engine, oversampled by SYS_CLK
// Assumes : pins already synchronised; SCLK below one eighth of clk
// Notes   : 16-bit instruction (read flag, 15-bit address), one byte
`timescale 1ns/1ps
module spi_frame_engine (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  input  wire logic  sclk_s,
  input  wire logic  cs_n_s,
  input  wire logic  sdi_s,
  output logic       sdo,
  output logic       sdo_oe_n,
  spi_frame_if.engine bus
);
  typedef enum logic [1:0] {INSTR, DATA, DONE} frame_state_type;

  frame_state_type                           state, next_state;
  logic [rx_phy_ctrl_pkg::INSTR_BITS-1:0]    shift_in, next_shift_in;
  logic [rx_phy_ctrl_pkg::CNT_W-1:0]         count, next_count;
  logic [rx_phy_ctrl_pkg::DATA_W-1:0]        sout, next_sout;
  logic [rx_phy_ctrl_pkg::ADDR_W-1:0]        addr, next_addr;
  logic [rx_phy_ctrl_pkg::DATA_W-1:0]        wdata, next_wdata;
  logic                                      is_read, next_is_read;
  logic                                      loaded, next_loaded;
  logic                                      wr_strobe, next_wr_strobe;
  logic                                      rd_strobe, next_rd_strobe;
  logic                                      sclk_prev;
  logic                                      rise;
  logic                                      fall;

  assign rise = sclk_s & ~sclk_prev;
  assign fall = ~sclk_s & sclk_prev;

  // ==========================================================
  // frame decode
  always_comb begin
    next_state     = state;
    next_shift_in  = shift_in;
    next_count     = count;
    next_sout      = sout;
    next_addr      = addr;
    next_wdata     = wdata;
    next_is_read   = is_read;
    next_loaded    = loaded;
    next_wr_strobe = 1'b0;
    next_rd_strobe = 1'b0;
    if (cs_n_s) begin
      // a frame cut short is dropped whole, nothing is written
      next_state  = INSTR;
      next_count  = '0;
      next_loaded = 1'b0;
    end else begin
      if (rise && state != DONE) begin
        next_shift_in = {shift_in[rx_phy_ctrl_pkg::INSTR_BITS-2:0], sdi_s};
        next_count    = count + 5'h01;
      end
      case (state)
        INSTR: begin
          if (rise && count == 5'h0F) begin
            next_state     = DATA;
            next_count     = '0;
            next_is_read   = shift_in[rx_phy_ctrl_pkg::BIT_READ-1];
            next_addr      = {shift_in[rx_phy_ctrl_pkg::ADDR_W-2:0], sdi_s};
            next_rd_strobe = shift_in[rx_phy_ctrl_pkg::BIT_READ-1];
          end
        end
        DATA: begin
          if (rise && count == 5'h07) begin
            next_state     = DONE;
            next_wdata     = {shift_in[rx_phy_ctrl_pkg::DATA_W-2:0], sdi_s};
            next_wr_strobe = ~is_read;
          end
          if (fall && is_read) begin
            // first falling edge presents the MSB, later ones shift
            next_loaded = 1'b1;
            next_sout   = loaded ? {sout[6:0], 1'b0} : bus.rdata;
          end
        end
        DONE: begin
          next_state = DONE;
        end
        default: begin
          next_state = INSTR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= INSTR;
      shift_in  <= '0;
      count     <= '0;
      sout      <= '0;
      addr      <= '0;
      wdata     <= '0;
      is_read   <= 1'b0;
      loaded    <= 1'b0;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      sclk_prev <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      shift_in  <= next_shift_in;
      count     <= next_count;
      sout      <= next_sout;
      addr      <= next_addr;
      wdata     <= next_wdata;
      is_read   <= next_is_read;
      loaded    <= next_loaded;
      wr_strobe <= next_wr_strobe;
      rd_strobe <= next_rd_strobe;
      sclk_prev <= sclk_s;
    end
  end

  assign bus.wr_strobe = wr_strobe;
  assign bus.rd_strobe = rd_strobe;
  assign bus.addr      = addr;
  assign bus.wdata     = wdata;
  assign sdo           = sout[rx_phy_ctrl_pkg::DATA_W-1];
  assign sdo_oe_n      = ~(~cs_n_s & is_read & (state != INSTR));
endmodule

// file: include/rx_phy_ctrl_pkg.sv
// Purpose : constants for the serial receiver control bank
// Assumes : byte-wide registers behind a serial control port
// Notes   : offsets are the byte addresses of the control port
package rx_phy_ctrl_pkg;
  // ==========================================================
  // serial frame layout
  localparam int ADDR_W        = 15;
  localparam int DATA_W        = 8;
  localparam int INSTR_BITS    = 16;
  localparam int CNT_W         = 5;
  localparam int SYNC_STAGES   = 2;
  localparam int LANES         = 4;

  // ==========================================================
  // register offsets
  localparam logic [14:0] OFF_RECEIVER_MASTER_POWER_DOWN = 15'h0200;
  localparam logic [14:0] OFF_LANE_PD   = 15'h0201;
  localparam logic [14:0] OFF_MISC_PD   = 15'h0203;
  localparam logic [14:0] OFF_REC_RST   = 15'h0206;
  localparam logic [14:0] OFF_OP_MODE   = 15'h0230;

  // ==========================================================
  // values after reset
  localparam logic [7:0] RST_RECEIVER_MASTER_POWER_DOWN = 8'h01;
  localparam logic [7:0] RST_LANE_PD   = 8'h00;
  localparam logic [7:0] RST_MISC_PD   = 8'h00;
  localparam logic [7:0] RST_REC_RST   = 8'h01;
  localparam logic [7:0] RST_OP_MODE   = 8'h28;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // field positions
  localparam int BIT_RECEIVER_MASTER_POWER_DOWN  = 0;
  localparam int BIT_SYNC_PD    = 1;
  localparam int BIT_REC_RST_N  = 0;
  localparam int BIT_HALF_RATE  = 5;
  localparam int BIT_OVERSAMPLE = 1;
  localparam int BIT_SWING      = 0;
  localparam int BIT_READ       = 15;
endpackage

// file: include/spi_frame_if.sv
// Purpose : carries decoded register accesses from the frame engine
// Assumes : strobes are one SYS_CLK cycle wide
// Notes   : rdata must be valid one cycle after rd_strobe
`timescale 1ns/1ps
interface spi_frame_if;
  logic                                wr_strobe;
  logic                                rd_strobe;
  logic [rx_phy_ctrl_pkg::ADDR_W-1:0]  addr;
  logic [rx_phy_ctrl_pkg::DATA_W-1:0]  wdata;
  logic [rx_phy_ctrl_pkg::DATA_W-1:0]  rdata;

  modport engine (output wr_strobe, output rd_strobe, output addr,
                  output wdata, input rdata);
  modport regs   (input wr_strobe, input rd_strobe, input addr,
                  input wdata, output rdata);
endinterface

// file: verif/spi_host_model.sv
// Purpose : serial control port host for the receiver control bank
// Assumes : SYS_CLK oversamples the port clock by sixteen
// Notes   : every pin changes on a falling SYS_CLK edge
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clk,
  input  wire logic sdo,
  input  wire logic sdo_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi
);
  localparam int HALF = 8;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // ==========================================================
  // one frame: read flag, address, byte; short nbits aborts
  task automatic frame(input logic rd, input logic [14:0] a,
                       input logic [7:0] d, input int nbits,
                       output logic [7:0] q, output int oe_cnt);
    logic [23:0] word;
    word = {rd, a, d};
    q = 8'h00;
    oe_cnt = 0;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi = word[23-i];
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      if (i >= 16) begin
        q[23-i] = sdo;
        if (sdo_oe_n === 1'b0) oe_cnt++;
      end
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    // deselected data line must not keep its last value
    repeat (HALF) begin
      @(negedge clk);
      sdi = ~sdi;
    end
  endtask
endmodule

// file: verif/tb.sv
// Purpose : self-checking bench for the receiver control bank
// Assumes : a reference copy of the registers predicts every result
// Notes   : stimulus from a fixed-seed xorshift generator
`timescale 1ns/1ps
module tb;
  logic       sys_clk;
  logic       reset_n;
  logic       clk_en;
  logic       sclk;
  logic       cs_n;
  logic       sdi;
  logic       sdo;
  logic       sdo_oe_n;
  logic       rx_pd;
  logic       bias_pd;
  logic [3:0] lane_pd;
  logic       sync_pd;
  logic       rec_rst_n;
  logic       half_en;
  logic       ovs_en;
  logic       swing;
  logic [7:0] q;
  logic [7:0] d;
  logic [31:0] seed;
  logic [31:0] r;
  logic [7:0] mdl [int];
  int         oe;
  int         a;
  int         bad_count;
  int         checked;
  int         addrs [7] = '{'h200, 'h201, 'h203, 'h206, 'h230, 'h202, 'h7FFF};
  logic [7:0] modes [4] = '{8'h28, 8'h0A, 8'h08, 8'h09};

  serial_rx_phy_control_regs serial_rx_phy_control_regs_inst (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
    .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo),
    .SDO_OE_N(sdo_oe_n), .RECEIVER_POWER_DOWN_ALL(rx_pd),
    .BIAS_POWER_DOWN(bias_pd), .LANE_POWER_DOWN(lane_pd),
    .SYNC_OUT_BUFFER_POWER_DOWN(sync_pd), .RECOVERY_RESET_N(rec_rst_n),
    .HALF_RATE_RECOVERY_ENABLE(half_en),
    .INPUT_OVERSAMPLE_ENABLE(ovs_en), .SYNC_OUT_SWING_SELECT(swing)
  );

  spi_host_model host_inst (
    .clk(sys_clk), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic init_model();
    mdl['h200] = 8'h01;
    mdl['h201] = 8'h00;
    mdl['h203] = 8'h00;
    mdl['h206] = 8'h01;
    mdl['h230] = 8'h28;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic check_oe(input int got, input int exp);
    checked++;
    if (got != exp) begin
      bad_count++;
      $display("unexpected at %0t: enable seen %0d bits", $time, got);
    end
  endtask

  task automatic check_outs();
    logic [10:0] got;
    logic [10:0] exp;
    logic        m;
    m = mdl['h200][0];
    exp = {m, m, mdl['h201][3:0] | {4{m}}, mdl['h203][1], mdl['h206][0],
           mdl['h230][5], mdl['h230][1], mdl['h230][0]};
    got = {rx_pd, bias_pd, lane_pd, sync_pd, rec_rst_n, half_en, ovs_en,
           swing};
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: outputs %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic wr(input int adr, input logic [7:0] v, input int nbits);
    host_inst.frame(1'b0, adr[14:0], v, nbits, q, oe);
    // a frozen or cut frame must leave the bank untouched
    if (nbits == 24 && clk_en === 1'b1 && mdl.exists(adr)) mdl[adr] = v;
  endtask

  task automatic rd(input int adr);
    host_inst.frame(1'b1, adr[14:0], 8'h00, 24, q, oe);
    check8(q, mdl.exists(adr) ? mdl[adr] : 8'h00);
    check_oe(oe, 8);
  endtask

  task automatic check_all();
    check_outs();
    foreach (addrs[i]) rd(addrs[i]);
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    reset_n = 1'b0;
    repeat (20) @(negedge sys_clk);
    reset_n = 1'b1;
    init_model();
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    seed = 32'hf206ff97;
    bad_count = 0;
    checked = 0;
    do_reset();
    check_all();
    wr('h200, 8'h00, 24);
    for (int x = 0; x < 4; x++) begin
      wr('h201, 8'h01 << x, 24);
      check_outs();
    end
    wr('h200, 8'hFF, 24);
    check_outs();
    wr('h200, 8'h00, 24);
    wr('h201, 8'h00, 24);
    foreach (modes[i]) begin
      wr('h206, 8'h00, 24);
      check_outs();
      wr('h230, modes[i], 24);
      check_outs();
      wr('h206, 8'h01, 24);
      check_outs();
    end
    wr('h203, 8'h02, 24);
    check_outs();
    wr('h203, 8'hFD, 24);
    check_outs();
    repeat (25) begin
      r = xorshift();
      a = addrs[r[18:16] % 7];
      d = r[7:0];
      if (a == 'h230) d[4:2] = 3'b010;
      wr(a, d, 24);
      check_outs();
      rd(a);
    end
    wr('h201, ~mdl['h201], 20);
    check_outs();
    rd('h201);
    @(negedge sys_clk);
    clk_en = 1'b0;
    wr('h203, ~mdl['h203], 24);
    @(negedge sys_clk);
    clk_en = 1'b1;
    repeat (8) @(negedge sys_clk);
    check_outs();
    rd('h203);
    wr('h200, 8'h00, 24);
    wr('h230, 8'h0B, 24);
    do_reset();
    check_all();
    report_and_stop();
  end

  // budget is about twice the expected run
  initial begin
    repeat (80000) @(posedge sys_clk);
    bad_count++;
    report_and_stop();
  end
endmodule
